/* File: fcst_regs.svh */
// Constants of the fibre coupling status and trigger block: offsets,
// field positions, reset values and timing counts.
// Assumes an APB slave on pclk at 100 MHz, 32-bit aligned words.
// Overview of operation
// - Eight separate indicator outputs show module and port pair state
// - Run/fault: both dark power-up, fault only unconfigured, run only working
// - Run and fault both lit after supply rail or hardware failure
// - Pair A startup lit while startup frames sent (master) or received (slave)
// - Pair A traffic lit when data accesses on pair A are acknowledged
// - Traffic indicator brightness follows intensity of periodic data traffic
// - Pair B startup shows startup frame sending in master mode only
// - Pair B traffic lit on remote acknowledgements, master mode only
// - Pair A link lit while its receiver sees a valid signal
// - Pair B link lit on valid receive signal, master mode only
// - Master mode sends clock, alarm and sampling triggers over links
// - Slave mode drives received triggers to backplane per routing enables
// - Coupling recovers automatically after the remote rack power cycles; a local failure latches until reset
// - Alarm interrupt on backplane carries no source identification
// - Master mode default serves two pairs; slave uses only pair A
`ifndef FCST_REGS_SVH
`define FCST_REGS_SVH

`define FCST_CTRL_OFS      12'h000
`define FCST_STATUS_OFS    12'h004
`define FCST_IRQ_STAT_OFS  12'h008
`define FCST_IRQ_MASK_OFS  12'h00C
`define FCST_ID_OFS        12'h010

// Control fields
`define FCST_CTRL_SLAVE    0
`define FCST_CTRL_INIT     1
`define FCST_CTRL_RT_CLK   2
`define FCST_CTRL_RT_ALM   3
`define FCST_CTRL_RT_BST   4
`define FCST_CTRL_RESET    32'h0000_0000

// Status fields
`define FCST_ST_RUN        0
`define FCST_ST_FAULT      1
`define FCST_ST_B_VALID    2
`define FCST_ST_A_VALID    3
`define FCST_ST_HW_FAIL    4

// Interrupt events
`define FCST_EV_A_LOSS     0
`define FCST_EV_B_LOSS     1
`define FCST_EV_FAIL       2
`define FCST_EV_ALARM      3
`define FCST_EV_W          4

// Traffic brightness: window in ms, cycles at 100 MHz
`define FCST_CLK_MHZ       100
`define FCST_WIN_MS        10
`define FCST_WIN_CYC       (`FCST_WIN_MS * 1000 * `FCST_CLK_MHZ)
`define FCST_PWM_W         4

`endif

/* File: fcst_pkg.sv */
// Types of the fibre coupling status and trigger block.
// Assumes fcst_regs.svh supplies the numeric constants.
`include "fcst_regs.svh"
package fcst_pkg;

  typedef struct packed {
    logic clock_trig;
    logic alarm_trig;
    logic base_trig;
  } fcst_trig_t;

  typedef struct packed {
    logic run_indicator;
    logic fault_indicator;
    logic pair_a_startup_indicator;
    logic pair_a_traffic_indicator;
    logic pair_b_startup_indicator;
    logic pair_b_traffic_indicator;
    logic pair_a_link_indicator;
    logic pair_b_link_indicator;
  } fcst_ind_t;

  typedef struct packed {
    logic startup;
    logic ack;
    logic valid;
  } fcst_pair_t;

  typedef struct packed {
    logic                     ready;
    logic [31:0]              rdata;
    logic                     slverr;
  } fcst_apb_rsp_t;

endpackage : fcst_pkg

/* File: fcst_top.sv */
// Status, indicator and trigger forwarding logic of the fibre coupling.
// Assumes link, supply and backplane signals are asynchronous pins and
// software reaches the control and status words over APB.
`timescale 1ns/100ps
`include "fcst_regs.svh"
module fcst_top #(
  parameter int WIN_CYC = `FCST_WIN_CYC,
  parameter int PWM_W   = `FCST_PWM_W
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 supply_ok,
  input  wire logic                 hw_fail,
  input  wire fcst_pkg::fcst_pair_t pair_a_in,
  input  wire fcst_pkg::fcst_pair_t pair_b_in,
  input  wire fcst_pkg::fcst_trig_t trig_local,
  input  wire fcst_pkg::fcst_trig_t trig_link_rx,
  output fcst_pkg::fcst_trig_t      trig_link_a_tx,
  output fcst_pkg::fcst_trig_t      trig_link_b_tx,
  output fcst_pkg::fcst_trig_t      trig_backplane,
  output fcst_pkg::fcst_ind_t       indicators,
  output logic                      irq
);

  localparam int SW = 3 + 3 + 1 + 3 + 1;

  typedef struct packed {
    logic [SW-1:0]              s1;
    logic [SW-1:0]              s2;
    logic [SW-1:0]              s3;
    logic [31:0]                ctrl;
    logic [`FCST_EV_W-1:0]      ists;
    logic [`FCST_EV_W-1:0]      imsk;
    logic [31:0]                wcnt;
    logic [PWM_W-1:0]           acnt_a;
    logic [PWM_W-1:0]           acnt_b;
    logic [PWM_W-1:0]           duty_a;
    logic [PWM_W-1:0]           duty_b;
    logic [PWM_W-1:0]           phase;
    logic                       fail_seen;
    logic                       pready;
    logic [31:0]                prdata;
    logic                       pslverr;
    fcst_pkg::fcst_trig_t       tx_a;
    fcst_pkg::fcst_trig_t       tx_b;
    fcst_pkg::fcst_trig_t       bp;
    fcst_pkg::fcst_ind_t        ind;
    logic                       irq;
  } fcst_state_t;

  fcst_state_t q;
  fcst_state_t next_q;

  // Sampled pins: a{st,ack,val}, b{st,ack,val}, supply_ok, trig_link_rx, hw
  logic [SW-1:0] raw;
  assign raw = {pair_a_in, pair_b_in, supply_ok, trig_link_rx, hw_fail};

  always_comb begin
    logic                 slave;
    logic                 a_st, a_ack, a_val, b_st, b_ack, b_val;
    logic                 sup_ok, hw, b_val_old, a_val_old, sup_old, hw_old;
    logic                 alm_rise;
    fcst_pkg::fcst_trig_t rx;
    fcst_pkg::fcst_trig_t rx_old;
    logic                 fail;
    logic                 wr, rd, acc;
    logic [`FCST_EV_W-1:0] ev;
    logic [`FCST_EV_W-1:0] clr;
    slave     = 1'b0;
    a_st      = 1'b0;
    a_ack     = 1'b0;
    a_val     = 1'b0;
    b_st      = 1'b0;
    b_ack     = 1'b0;
    b_val     = 1'b0;
    sup_ok    = 1'b0;
    hw        = 1'b0;
    a_val_old = 1'b0;
    b_val_old = 1'b0;
    sup_old   = 1'b0;
    hw_old    = 1'b0;
    alm_rise  = 1'b0;
    rx        = '0;
    rx_old    = '0;
    fail      = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    acc       = 1'b0;
    ev        = '0;
    clr       = '0;
    next_q    = q;

    next_q.s1 = raw;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    {a_st, a_ack, a_val, b_st, b_ack, b_val, sup_ok, rx, hw} = q.s2;
    {a_val_old, b_val_old, sup_old, hw_old} =
      {q.s3[8], q.s3[5], q.s3[4], q.s3[0]};
    rx_old   = q.s3[3:1];
    alm_rise = rx.alarm_trig & ~rx_old.alarm_trig;
    slave    = q.ctrl[`FCST_CTRL_SLAVE];

    // A rail that falls after being good, or a hardware fault, latches
    // the failure until reset; a rail still rising at power-up does not
    if ((sup_old && !sup_ok) || hw) begin
      next_q.fail_seen = 1'b1;
    end
    fail = q.fail_seen;

    // Indicators
    next_q.ind.run_indicator   = q.ctrl[`FCST_CTRL_INIT] | fail;
    next_q.ind.fault_indicator = ~q.ctrl[`FCST_CTRL_INIT] | fail;
    if (!q.ctrl[`FCST_CTRL_INIT] && !fail && !sup_ok) begin
      next_q.ind.run_indicator   = 1'b0;
      next_q.ind.fault_indicator = 1'b0;
    end
    next_q.ind.pair_a_startup_indicator = a_st;
    next_q.ind.pair_a_link_indicator    = a_val;
    next_q.ind.pair_b_startup_indicator = ~slave & b_st;
    next_q.ind.pair_b_link_indicator    = ~slave & b_val;

    // Ack density per window sets duty; PWM gives brightness
    next_q.phase = q.phase + 1'b1;
    if (q.wcnt >= 32'(WIN_CYC - 1)) begin
      next_q.wcnt   = '0;
      next_q.duty_a = q.acnt_a;
      next_q.duty_b = q.acnt_b;
      next_q.acnt_a = '0;
      next_q.acnt_b = '0;
    end else begin
      next_q.wcnt = q.wcnt + 32'h0000_0001;
      if (a_ack && q.acnt_a != '1) begin
        next_q.acnt_a = q.acnt_a + 1'b1;
      end
      if (b_ack && q.acnt_b != '1) begin
        next_q.acnt_b = q.acnt_b + 1'b1;
      end
    end
    next_q.ind.pair_a_traffic_indicator =
      (q.duty_a != '0) && (q.phase <= q.duty_a);
    next_q.ind.pair_b_traffic_indicator = ~slave &
      (q.duty_b != '0) && (q.phase <= q.duty_b);

    // Triggers: master sends on both links, slave routes to backplane
    next_q.tx_a = slave ? '0 : trig_local;
    next_q.tx_b = slave ? '0 : trig_local;
    next_q.bp.clock_trig = slave & q.ctrl[`FCST_CTRL_RT_CLK]
                           & rx.clock_trig;
    next_q.bp.alarm_trig = slave & q.ctrl[`FCST_CTRL_RT_ALM]
                           & rx.alarm_trig;
    next_q.bp.base_trig  = slave & q.ctrl[`FCST_CTRL_RT_BST]
                           & rx.base_trig;

    // Events; link loss needs no software action to recover
    ev[`FCST_EV_A_LOSS] = a_val_old & ~a_val;
    ev[`FCST_EV_B_LOSS] = ~slave & b_val_old & ~b_val;
    ev[`FCST_EV_FAIL]   = (sup_old & ~sup_ok) | (~hw_old & hw);
    ev[`FCST_EV_ALARM]  = slave & alm_rise;

    // APB: one wait state; reads are staged, writes land at the pready edge
    acc = psel & penable;
    wr  = acc & pwrite;
    rd  = acc & ~pwrite;
    next_q.pready  = 1'b0;
    next_q.pslverr = 1'b0;
    next_q.prdata  = '0;
    if (acc && !q.pready) begin
      next_q.pready = 1'b1;
      case (paddr)
        `FCST_CTRL_OFS: begin
          next_q.prdata = q.ctrl;
        end
        `FCST_STATUS_OFS: begin
          next_q.prdata = {27'h000_0000, hw, a_val, b_val,
                           q.ind.fault_indicator, q.ind.run_indicator};
        end
        `FCST_IRQ_STAT_OFS: begin
          next_q.prdata = {28'h000_0000, q.ists};
        end
        `FCST_IRQ_MASK_OFS: begin
          next_q.prdata = {28'h000_0000, q.imsk};
        end
        `FCST_ID_OFS: begin
          next_q.prdata = 32'h0000_5A01; // Arbitrary value
        end
        default: begin
          next_q.pslverr = 1'b1;
        end
      endcase
      if (rd) begin
        next_q.prdata = next_q.prdata;
      end else begin
        next_q.prdata = '0;
      end
    end
    // Write takes effect at the edge where the master sees pready high
    if (wr && q.pready) begin
      case (paddr)
        `FCST_CTRL_OFS: begin
          next_q.ctrl = {27'h000_0000, pwdata[4:0]};
        end
        `FCST_IRQ_STAT_OFS: begin
          clr = pwdata[`FCST_EV_W-1:0];
        end
        `FCST_IRQ_MASK_OFS: begin
          next_q.imsk = pwdata[`FCST_EV_W-1:0];
        end
        default: begin
          clr = '0;
        end
      endcase
    end
    // Set wins over write-one-to-clear
    next_q.ists = (q.ists & ~clr) | ev;
    next_q.irq  = |(next_q.ists & next_q.imsk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q      <= '0;
    end else begin
      q      <= next_q;
    end
  end

  assign pready         = q.pready;
  assign prdata         = q.prdata;
  assign pslverr        = q.pslverr;
  assign trig_link_a_tx = q.tx_a;
  assign trig_link_b_tx = q.tx_b;
  assign trig_backplane = q.bp;
  assign indicators     = q.ind;
  assign irq            = q.irq;

endmodule : fcst_top

/* File: fcst_asserts.sv */
// Port checker of the fibre coupling status and trigger block.
// Assumes fcst_top on pclk with the async reset presetn.
`timescale 1ns/100ps
module fcst_asserts #(
  parameter int WIN_CYC = 64,
  parameter int PWM_W   = 4
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire fcst_pkg::fcst_pair_t pair_a_in,
  input wire fcst_pkg::fcst_pair_t pair_b_in,
  input wire fcst_pkg::fcst_trig_t trig_local,
  input wire fcst_pkg::fcst_trig_t trig_link_rx,
  input wire fcst_pkg::fcst_trig_t trig_link_a_tx,
  input wire fcst_pkg::fcst_trig_t trig_link_b_tx,
  input wire fcst_pkg::fcst_trig_t trig_backplane,
  input wire fcst_pkg::fcst_ind_t  indicators
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  tx_a_source_a: assert property
    ((trig_link_a_tx & ~$past(trig_local)) == 3'h0) else $error("tx a");
  tx_b_source_a: assert property
    ((trig_link_b_tx & ~$past(trig_local)) == 3'h0) else $error("tx b");
  backplane_source_a: assert property
    ((trig_backplane & ~$past(trig_link_rx, 3)) == 3'h0) else $error("bp");
  a_link_valid_a: assert property (indicators.pair_a_link_indicator
    |-> $past(pair_a_in.valid, 3)) else $error("a link");
  b_link_valid_a: assert property (indicators.pair_b_link_indicator
    |-> $past(pair_b_in.valid, 3)) else $error("b link");
  a_startup_src_a: assert property
    (indicators.pair_a_startup_indicator |-> $past(pair_a_in.startup, 3))
    else $error("a startup");
  cover property (indicators.pair_a_link_indicator);
  cover property (trig_backplane != 3'h0);
  cover property (pslverr);
endmodule : fcst_asserts

bind fcst_top fcst_asserts #(.WIN_CYC(WIN_CYC), .PWM_W(PWM_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
  .pair_a_in(pair_a_in), .pair_b_in(pair_b_in), .trig_local(trig_local),
  .trig_link_rx(trig_link_rx), .trig_link_a_tx(trig_link_a_tx),
  .trig_link_b_tx(trig_link_b_tx), .trig_backplane(trig_backplane),
  .indicators(indicators));

/* File: fcst_peer.sv */
// Peer coupling module at the far end of one fibre port pair.
// Assumes the bench powers it with up and paces its acks with gap.
`timescale 1ns/100ps
module fcst_peer (
  input  wire logic                 pclk,
  input  wire logic                 up,
  input  wire logic [3:0]           gap,
  input  wire fcst_pkg::fcst_trig_t tcmd,
  output fcst_pkg::fcst_pair_t      pair = '0,
  output fcst_pkg::fcst_trig_t      trig = '0
);
  int cnt = 0;
  always @(posedge pclk) begin
    cnt <= up ? cnt + 1 : 0; // Link restarts on each power-up
    pair.startup <= up && cnt < 20;
    pair.valid <= up;
    pair.ack <= up && cnt >= 20 && cnt % (gap + 1) == 0;
    trig <= up ? tcmd : ~trig;
  end
endmodule : fcst_peer

/* File: fcst_top_tb.sv */
// Self-checking bench of fcst_top with two peers and an APB master.
// Assumes the checker and peer model are compiled first.
`timescale 1ns/100ps
module fcst_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic supply_ok = 0, hw_fail = 0, up_a = 0, up_b = 0, pready, pslverr, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] gap_a = 0, gap_b = 4'h3;
  fcst_pkg::fcst_trig_t tl = '0, tcmd = '0, rx, txa, txb, bp, q[$];
  fcst_pkg::fcst_pair_t pa, pb;
  fcst_pkg::fcst_ind_t ind;
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 73, lit[3];
  initial forever #5 pclk = ~pclk;
  fcst_top #(.WIN_CYC(64), .PWM_W(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_ok(supply_ok), .hw_fail(hw_fail), .pair_a_in(pa),
    .pair_b_in(pb), .trig_local(tl), .trig_link_rx(rx),
    .trig_link_a_tx(txa), .trig_link_b_tx(txb), .trig_backplane(bp),
    .indicators(ind), .irq(irq));
  fcst_peer peer_a (.pclk(pclk), .up(up_a), .gap(gap_a), .tcmd(tcmd),
    .pair(pa), .trig(rx));
  fcst_peer peer_b (.pclk(pclk), .up(up_b), .gap(gap_b), .tcmd(tcmd),
    .pair(pb), .trig());
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask : w
  task automatic apb(input logic wr, input logic [11:0] a, logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    w(6);
    presetn <= 1;
    w(5);
    chk(ind, 8'h00);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    apb(0, 12'h020, 0);
    chk(er, 1);
    supply_ok <= 1;
    w(5);
    chk(ind & 8'hEB, 8'h40);
    apb(1, 12'h000, 32'h0000_0002);
    up_a <= 1;
    up_b <= 1;
    w(6);
    chk(ind & 8'hEB, 8'hAB);
    w(30);
    chk(ind & 8'hEB, 8'h83);
    $display("status and link test done");
    for (int k = 0; k < 2; k++) begin
      w(200);
      lit[k] = 0;
      repeat (512) begin
        @(posedge pclk);
        lit[k] += ind.pair_a_traffic_indicator;
        lit[2] += ind.pair_b_traffic_indicator;
      end
      gap_a <= 4'hF;
    end
    chk(lit[0] > lit[1] && lit[1] > 0, 1);
    chk(lit[2] > 0, 1);
    $display("traffic test done");
    repeat (40) begin
      @(posedge pclk);
      if (q.size() == 2) chk({txa, txb, bp}, {q[0], q[0], 3'h0});
      if (q.size() == 2) void'(q.pop_front());
      q.push_back(3'($random(seed)));
      tl <= q[$];
    end
    apb(1, 12'h00C, 32'h0000_0008);
    for (int r = 0; r < 8; r++) begin
      apb(1, 12'h000, {27'h0, 3'(r), 2'h3});
      repeat (4) begin
        tcmd <= 3'($random(seed));
        tl <= 3'($random(seed));
        w(5);
        chk({txa, txb, bp}, {6'h0, tcmd & {r[0], r[1], r[2]}});
      end
    end
    chk(ind & 8'h0D, 8'h00);
    tcmd <= 0;
    w(5);
    chk(irq, 1);
    apb(1, 12'h00C, 0);
    chk(irq, 0);
    apb(1, 12'h00C, 32'h0000_0008);
    apb(1, 12'h008, 32'h0000_0008);
    w(2);
    chk(irq, 0);
    $display("trigger and interrupt test done");
    hw_fail <= 1;
    up_a <= 0;
    w(5);
    chk(ind & 8'hC2, 8'hC0);
    presetn <= 0;
    hw_fail <= 0;
    w(6);
    presetn <= 1;
    up_a <= 1;
    w(2);
    apb(1, 12'h000, 32'h0000_0002);
    w(30);
    chk(ind & 8'hEB, 8'h83);
    $display("failure and recovery test done");
    conclude();
  end
endmodule : fcst_top_tb
